// ### verification/rtc_host_model.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// host side byte register requester
// ---------------------------------------------------------------
module rtc_host_model (
  input  wire logic         i_sys_clk,
  input  wire logic [7:0]   i_rdata,
  output rtc_pkg::reg_req_t o_reg
);
  initial o_reg = '0;

  // one request held over one sampling edge, then scrambled
  task automatic xfer(input logic [7:0] a, input logic [7:0] d,
                      input logic w);
    @(posedge i_sys_clk);
    o_reg <= '{addr: a, wdata: d, wr: w, rd: ~w};
    @(posedge i_sys_clk);
    o_reg <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == 8'h08) v[6] = 1'b0;
    xfer(a, v, 1'b1);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    xfer(a, 8'h00, 1'b0);
    #1 d = i_rdata;
  endtask : rd

  task automatic stop_timer(input logic [7:0] ctrl);
    wr(8'h03, ctrl & 8'hcf);
  endtask : stop_timer
endmodule : rtc_host_model

// ### verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic                i_sys_clk = 1'b0;
  logic                i_reset   = 1'b1;
  rtc_pkg::reg_req_t   req;
  rtc_pkg::rtc_events_t ev_q     = '0;
  logic [7:0]          init_q    = 8'h03;
  logic                live_q    = 1'b0;
  logic                en_q      = 1'b1;
  logic                load_q    = 1'b0;
  logic                ext_q     = 1'b0;
  logic                ana_q     = 1'b0;
  logic                dig_q     = 1'b0;
  logic [7:0]          rdata;
  logic [7:0]          cnt;
  logic [7:0]          v;
  logic                irq;
  int                  n_mismatch = 0;
  int                  n_checks   = 0;
  int                  n;

  always #2.5 i_sys_clk = ~i_sys_clk;

  rtc_timer_irq_time_regs #(.DIV_CYCLES(2)) u_dut (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_clk_en(en_q),
    .i_reg(req), .o_rdata(rdata), .i_countdown_init_value(init_q),
    .i_time_read_live(live_q), .i_time_load(load_q),
    .i_external_reference_enable(ext_q), .i_events(ev_q),
    .i_analog_input_pin(ana_q), .i_digital_event_input(dig_q),
    .o_irq(irq), .o_countdown_value(cnt));

  rtc_host_model u_host (
    .i_sys_clk(i_sys_clk), .i_rdata(rdata), .o_reg(req));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(string nm, logic [7:0] got, logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  task automatic cyc(int k);
    repeat (k) @(posedge i_sys_clk);
    #1;
  endtask : cyc

  task automatic rchk(string nm, logic [7:0] a, logic [7:0] exp);
    logic [7:0] d;
    u_host.rd(a, d);
    chk(nm, d, exp);
  endtask : rchk

  // bounded wait on the count, then compare
  task automatic wait_cnt(logic [7:0] x);
    for (int k = 0; k < 400 && cnt !== x; k++) cyc(1);
    chk("count", cnt, x);
  endtask : wait_cnt

  // cycles between two successive count changes
  task automatic gap(output int g);
    logic [7:0] p;
    p = cnt;
    for (int k = 0; k < 300 && cnt === p; k++) cyc(1);
    p = cnt;
    g = 0;
    while (cnt === p && g < 300)
    begin
      cyc(1);
      g++;
    end
  endtask : gap

  task automatic pulse(rtc_pkg::rtc_events_t e);
    @(posedge i_sys_clk);
    ev_q <= e;
    @(posedge i_sys_clk);
    ev_q <= '0;
    cyc(1);
  endtask : pulse

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    rchk("ctrl_rst", 8'h03, 8'h07);
    rchk("ien_rst", 8'h04, 8'h00);
    rchk("flags_rst", 8'h05, 8'h40);
    rchk("flags_clr", 8'h05, 8'h00);
    u_host.wr(8'h04, 8'hff);
    rchk("ien_mask", 8'h04, 8'h77);
    u_host.wr(8'h05, 8'hff);
    rchk("flags_ro", 8'h05, 8'h00);
    rchk("unmapped", 8'h20, 8'h00);
    u_host.wr(8'h06, 8'hff);
    rchk("sec_mask", 8'h06, 8'h7f);
    u_host.wr(8'h07, 8'h47);
    rchk("min", 8'h07, 8'h47);
    u_host.wr(8'h08, 8'h23);
    rchk("hours", 8'h08, 8'h23);
  endtask : t_regs

  task automatic t_count();
    u_host.wr(8'h04, 8'h04);
    u_host.wr(8'h03, 8'h10);
    wait_cnt(8'h00);
    cyc(20);
    chk("halted", cnt, 8'h00);
    chk("irq_on", irq, 1'b1);
    rchk("zero_flag", 8'h05, 8'h04);
    chk("irq_off", irq, 1'b0);
    u_host.wr(8'h03, 8'h14);
    wait_cnt(8'h00);
    wait_cnt(8'h03);
    u_host.stop_timer(8'h14);
    init_q <= 8'h07;
    cyc(3);
    chk("idle_init", cnt, 8'h07);
    for (int r = 0; r < 4; r++)
    begin
      u_host.wr(8'h03, 8'h14 | r[7:0]);
      gap(n);
      chk("rate_gap", n[7:0], 8'h02 << (2 * r));
      u_host.stop_timer(8'h14);
    end
  endtask : t_count

  task automatic t_hold();
    init_q <= 8'hc8;
    u_host.wr(8'h03, 8'h10);
    cyc(4);
    u_host.wr(8'h03, 8'h30);
    cyc(2);
    v = cnt;
    cyc(30);
    chk("frozen", cnt, v);
    u_host.wr(8'h03, 8'h10);
    cyc(10);
    chk("resumed", cnt !== v, 1'b1);
    // clock enable low freezes the running count
    @(posedge i_sys_clk);
    en_q <= 1'b0;
    cyc(2);
    v = cnt;
    cyc(20);
    chk("en_frozen", cnt, v);
    @(posedge i_sys_clk);
    en_q <= 1'b1;
    u_host.stop_timer(8'h30);
  endtask : t_hold

  task automatic t_events();
    u_host.wr(8'h04, 8'h41);
    pulse(4'b1001);
    chk("irq_alm1", irq, 1'b1);
    rchk("osc_masked", 8'h05, 8'h01);
    u_host.wr(8'h04, 8'h00);
    pulse(4'b1010);
    chk("irq_gated", irq, 1'b0);
    rchk("alm2_osc", 8'h05, 8'h42);
    pulse(4'b0100);
    rchk("drift_off", 8'h05, 8'h00);
    @(posedge i_sys_clk);
    ext_q <= 1'b1;
    pulse(4'b0100);
    rchk("drift_on", 8'h05, 8'h80);
    @(posedge i_sys_clk);
    ana_q <= 1'b1;
    cyc(8);
    rchk("analog", 8'h05, 8'h20);
    @(posedge i_sys_clk);
    dig_q <= 1'b1;
    cyc(8);
    rchk("digital", 8'h05, 8'h10);
  endtask : t_events

  task automatic t_time();
    u_host.wr(8'h06, 8'h59);
    u_host.wr(8'h07, 8'h59);
    u_host.wr(8'h08, 8'h23);
    load_q <= 1'b1;
    live_q <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    load_q <= 1'b0;
    v = 8'h59;
    for (int k = 0; k < 1400 && v === 8'h59; k++) u_host.rd(8'h06, v);
    chk("sec_wrap", v, 8'h00);
    rchk("min_wrap", 8'h07, 8'h00);
    rchk("hr_wrap", 8'h08, 8'h00);
    @(posedge i_sys_clk);
    live_q <= 1'b0;
    rchk("prog_sec", 8'h06, 8'h59);
  endtask : t_time

  initial
  begin
    repeat (10) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    cyc(1);
    t_regs();
    t_count();
    t_hold();
    t_events();
    t_time();
    stop_test();
  end

  initial
  begin
    repeat (60000) @(posedge i_sys_clk);
    n_mismatch++;
    stop_test();
  end
endmodule : tb_top

// ### verilog/rtc_pkg.sv
package rtc_pkg;

  // register port request from the serial front end
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  // event inputs from neighbouring logic on the same clock
  typedef struct packed {
    logic osc_halted;
    logic sync_drift;
    logic alarm_two;
    logic alarm_one;
  } rtc_events_t;

  // whole block state
  typedef struct packed {
    logic [17:0] div;
    logic [9:0]  sub;
    logic [7:0]  count;
    logic [7:0]  ctrl;
    logic [7:0]  ien;
    logic [7:0]  flags;
    logic [7:0]  prog_sec;
    logic [7:0]  prog_min;
    logic [7:0]  prog_hr;
    logic [7:0]  live_sec;
    logic [7:0]  live_min;
    logic [7:0]  live_hr;
    logic [7:0]  rdata;
    logic        load_prev;
    logic [2:0]  ana_sync;
    logic [2:0]  dig_sync;
    logic        ana_lvl;
    logic        dig_lvl;
  } rtc_state_t;

endpackage : rtc_pkg

// ### verilog/rtc_regs.svh
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define RTC_OFS_COUNTDOWN_CONTROL 8'h03
`define RTC_OFS_IRQ_ENABLE        8'h04
`define RTC_OFS_IRQ_FLAGS         8'h05
`define RTC_OFS_TIME_SECONDS      8'h06
`define RTC_OFS_TIME_MINUTES      8'h07
`define RTC_OFS_TIME_HOURS        8'h08

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define RTC_BIT_HOLD        5
`define RTC_BIT_RUN         4
`define RTC_BIT_AUTORELOAD  2
`define RTC_BIT_SYNC_DRIFT  7
`define RTC_BIT_OSC_HALTED  6
`define RTC_BIT_ANALOG      5
`define RTC_BIT_DIGITAL     4
`define RTC_BIT_ZERO        2
`define RTC_BIT_ALARM_TWO   1
`define RTC_BIT_ALARM_ONE   0
`define RTC_BIT_OSC_MASK    6

// ---------------------------------------------------------------
// masks, reset values and wrap limits
// ---------------------------------------------------------------
`define RTC_CTRL_MASK      8'h37
`define RTC_IEN_MASK       8'h77
`define RTC_FLAG_MASK      8'hf7
`define RTC_SEC_MASK       8'h7f
`define RTC_HOURS_MASK     8'h3f
`define RTC_CTRL_RESET     8'h07
`define RTC_IEN_RESET      8'h00
`define RTC_FLAGS_RESET    8'h40
`define RTC_TIME_RESET     8'h00
`define RTC_SEC_LAST       8'h59
`define RTC_HOURS_LAST     8'h23

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define RTC_CLK_HZ         200000000
`define RTC_BASE_TICK_HZ   1024
`define RTC_TICKS_PER_SEC  1024

`endif

// ### verilog/rtc_timer_irq_time_regs.sv
// What this block does
// - run bit low holds timer at its initial value, which may change.
// - setting run bit starts counting down from the initial value.
// - hold bit 5 freezes count while running; clearing it resumes.
// - autoreload bit 2 clear stops the timer at zero.
// - autoreload set reloads initial value at zero and keeps counting.
// - rate field 1:0 picks 1024, 256, 64 or 16 Hz countdown ticks.
// - analog, digital, zero and alarm sources each gated by own enable bit; drift and osc halted never interrupt.
// - enable bit 6 forces oscillator halted flag to read zero.
// - any read of the flag register clears all flags except those set in that cycle.
// - drift flag bit 7 set on drift only in external reference mode.
// - oscillator halted flag bit 6 set on stop, resets to one.
// - analog event flag bit 5 set on an analog input event.
// - digital event flag bit 4 set on a settled rising edge of the digital input.
// - zero flag bit 2 set when countdown reaches zero.
// - alarm two flag bit 1, alarm one flag bit 0 on triggers.
// - seconds hold BCD, tens in 6:4, units 3:0, bit 7 unused.
// - minutes hold BCD, tens in 6:4, units 3:0.
// - hours hold 24h BCD, tens 5:4, units 3:0, bit 6 zero.
// - read select returns live time or programmed time.
// - rising edge of load copies programmed time into live chain.
`timescale 1ns/10ps
`include "rtc_regs.svh"

module rtc_timer_irq_time_regs #(
  parameter int DIV_CYCLES = `RTC_CLK_HZ / `RTC_BASE_TICK_HZ
) (
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_reset,
  input  wire logic                 i_clk_en,
  input  wire rtc_pkg::reg_req_t    i_reg,
  output logic [7:0]                o_rdata,
  input  wire logic [7:0]           i_countdown_init_value,
  input  wire logic                 i_time_read_live,
  input  wire logic                 i_time_load,
  input  wire logic                 i_external_reference_enable,
  input  wire rtc_pkg::rtc_events_t i_events,
  input  wire logic                 i_analog_input_pin,
  input  wire logic                 i_digital_event_input,
  output logic                      o_irq,
  output logic [7:0]                o_countdown_value
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------

  // bcd increment with wrap at last; returns {carry, next}
  function automatic logic [8:0] bcd_step(input logic [7:0] v,
                                          input logic [7:0] last);
    logic [8:0] r;
    r = 9'h000;
    if (v == last)
      r = {1'b1, 8'h00};
    else if (v[3:0] == 4'h9)
      r = {1'b0, v[7:4] + 4'h1, 4'h0};
    else
      r = {1'b0, v[7:4], v[3:0] + 4'h1};
    return r;
  endfunction : bcd_step

  // countdown tick select from the 1024 Hz sub-count
  function automatic logic rate_hit(input logic [1:0] sel,
                                    input logic [9:0] sub);
    logic h;
    h = 1'b0;
    case (sel)
      2'h0:    h = 1'b1;
      2'h1:    h = (sub[1:0] == 2'h0);
      2'h2:    h = (sub[3:0] == 4'h0);
      default: h = (sub[5:0] == 6'h00);
    endcase
    return h;
  endfunction : rate_hit

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  rtc_pkg::rtc_state_t st_q;
  rtc_pkg::rtc_state_t st_d;

  logic       base_tick;
  logic       sec_tick;
  logic       cd_tick;
  logic       run;
  logic       hold;
  logic       autoreload;
  logic       wr_hit;
  logic       rd_flags;
  logic       load_edge;
  logic       ana_event;
  logic       dig_event;
  logic [7:0] set_flags;
  logic [7:0] flags_view;
  logic [8:0] sec_n;
  logic [8:0] min_n;
  logic [8:0] hr_n;

  // tick generation and decoded controls
  always_comb
  begin
    base_tick  = (st_q.div == 18'(DIV_CYCLES - 1));
    sec_tick   = base_tick
               && (st_q.sub == 10'(`RTC_TICKS_PER_SEC - 1));
    cd_tick    = base_tick && rate_hit(st_q.ctrl[1:0], st_q.sub);
    run        = st_q.ctrl[`RTC_BIT_RUN];
    hold       = st_q.ctrl[`RTC_BIT_HOLD];
    autoreload = st_q.ctrl[`RTC_BIT_AUTORELOAD];
    wr_hit     = i_reg.wr;
    rd_flags   = i_reg.rd && (i_reg.addr == `RTC_OFS_IRQ_FLAGS);
    load_edge  = i_time_load && !st_q.load_prev;
    ana_event  = (st_q.ana_sync[1] == st_q.ana_sync[2])
               && st_q.ana_sync[2] && !st_q.ana_lvl;
    dig_event  = (st_q.dig_sync[1] == st_q.dig_sync[2])
               && st_q.dig_sync[2] && !st_q.dig_lvl;
  end

  // event sources feeding the flag register
  always_comb
  begin
    set_flags = 8'h00;
    // drift only in external reference mode
    set_flags[`RTC_BIT_SYNC_DRIFT] = i_events.sync_drift
                                   && i_external_reference_enable;
    set_flags[`RTC_BIT_OSC_HALTED] = i_events.osc_halted;
    set_flags[`RTC_BIT_ANALOG]     = ana_event;
    set_flags[`RTC_BIT_DIGITAL]    = dig_event;
    // zero reached on a countdown step
    set_flags[`RTC_BIT_ZERO]       = run && !hold && cd_tick
                                   && (st_q.count == 8'h01);
    set_flags[`RTC_BIT_ALARM_TWO]  = i_events.alarm_two;
    set_flags[`RTC_BIT_ALARM_ONE]  = i_events.alarm_one;
    flags_view = st_q.flags;
    if (st_q.ien[`RTC_BIT_OSC_MASK])
      flags_view[`RTC_BIT_OSC_HALTED] = 1'b0;
  end

  // next-state logic
  always_comb
  begin
    st_d  = st_q;
    sec_n = bcd_step(st_q.live_sec, `RTC_SEC_LAST);
    min_n = bcd_step(st_q.live_min, `RTC_SEC_LAST);
    hr_n  = bcd_step(st_q.live_hr, `RTC_HOURS_LAST);

    // prescaler to 1024 Hz and one second
    st_d.div = base_tick ? 18'h0_0000 : st_q.div + 18'h0_0001;
    if (base_tick)
      st_d.sub = st_q.sub + 10'h001;

    // input pin synchronisers and settled levels
    st_d.ana_sync = {st_q.ana_sync[1:0], i_analog_input_pin};
    st_d.dig_sync = {st_q.dig_sync[1:0], i_digital_event_input};
    if (st_q.ana_sync[1] == st_q.ana_sync[2])
      st_d.ana_lvl = st_q.ana_sync[2];
    if (st_q.dig_sync[1] == st_q.dig_sync[2])
      st_d.dig_lvl = st_q.dig_sync[2];

    // countdown timer
    if (!run)
      st_d.count = i_countdown_init_value;
    else if (cd_tick && !hold)
    begin
      if (st_q.count != 8'h00)
        st_d.count = st_q.count - 8'h01;
      else if (autoreload)
        st_d.count = i_countdown_init_value;
    end

    // live time chain
    if (sec_tick)
    begin
      st_d.live_sec = sec_n[7:0];
      if (sec_n[8])
      begin
        st_d.live_min = min_n[7:0];
        if (min_n[8])
          st_d.live_hr = hr_n[7:0];
      end
    end
    st_d.load_prev = i_time_load;
    if (load_edge)
    begin
      st_d.live_sec = st_q.prog_sec;
      st_d.live_min = st_q.prog_min;
      st_d.live_hr  = st_q.prog_hr;
    end

    // register writes
    if (wr_hit)
    begin
      case (i_reg.addr)
        `RTC_OFS_COUNTDOWN_CONTROL:
          st_d.ctrl = i_reg.wdata & `RTC_CTRL_MASK;
        `RTC_OFS_IRQ_ENABLE:
          st_d.ien = i_reg.wdata & `RTC_IEN_MASK;
        `RTC_OFS_TIME_SECONDS:
          st_d.prog_sec = i_reg.wdata & `RTC_SEC_MASK;
        `RTC_OFS_TIME_MINUTES:
          st_d.prog_min = i_reg.wdata & `RTC_SEC_MASK;
        // hours layout, bit 6 kept zero
        `RTC_OFS_TIME_HOURS:
          st_d.prog_hr = i_reg.wdata & `RTC_HOURS_MASK;
        default:
          st_d.ctrl = st_q.ctrl;
      endcase
    end

    st_d.flags = (rd_flags ? 8'h00 : st_q.flags) | set_flags;

    // registered read data
    if (i_reg.rd)
    begin
      case (i_reg.addr)
        `RTC_OFS_COUNTDOWN_CONTROL: st_d.rdata = st_q.ctrl;
        `RTC_OFS_IRQ_ENABLE:        st_d.rdata = st_q.ien;
        `RTC_OFS_IRQ_FLAGS:         st_d.rdata = flags_view;
        `RTC_OFS_TIME_SECONDS:
          st_d.rdata = i_time_read_live ? st_q.live_sec : st_q.prog_sec;
        `RTC_OFS_TIME_MINUTES:
          st_d.rdata = i_time_read_live ? st_q.live_min : st_q.prog_min;
        `RTC_OFS_TIME_HOURS:
          st_d.rdata = i_time_read_live ? st_q.live_hr : st_q.prog_hr;
        default:                    st_d.rdata = 8'h00;
      endcase
    end
  end

  // state register, frozen while clock enable is low
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      st_q       <= '0;
      st_q.ctrl  <= `RTC_CTRL_RESET;
      st_q.ien   <= `RTC_IEN_RESET;
      st_q.flags <= `RTC_FLAGS_RESET;
    end
    else if (i_clk_en)
      st_q <= st_d;
  end

  // outputs
  always_comb
  begin
    o_rdata           = st_q.rdata;
    o_countdown_value = st_q.count;
    o_irq = |(flags_view & st_q.ien & `RTC_FLAG_MASK
              & ~(8'h01 << `RTC_BIT_OSC_MASK)
              & ~(8'h01 << `RTC_BIT_SYNC_DRIFT));
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  AST_FLAG_RESET: assert property (
    $fell(i_reset) |-> st_q.flags == `RTC_FLAGS_RESET)
    else $error("flags not at reset value");
  AST_IDLE_LOADS: assert property (
    i_clk_en && !run |=> st_q.count == $past(i_countdown_init_value))
    else $error("idle timer not at initial value");
  AST_HOLD_FREEZE: assert property (
    i_clk_en && run && hold && !wr_hit |=> $stable(st_q.count))
    else $error("held timer moved");
  AST_STOP_ZERO: assert property (
    i_clk_en && run && !autoreload && st_q.count == 8'h00 && !wr_hit
    |=> st_q.count == 8'h00)
    else $error("timer left zero without reload");
  AST_RELOAD: assert property (
    i_clk_en && run && autoreload && !hold && cd_tick
    && st_q.count == 8'h00 && !wr_hit
    |=> st_q.count == $past(i_countdown_init_value))
    else $error("timer did not reload");
  AST_ZERO_FLAG: assert property (
    i_clk_en && run && !hold && cd_tick && st_q.count == 8'h01
    && !wr_hit |=> st_q.count == 8'h00 && st_q.flags[`RTC_BIT_ZERO])
    else $error("zero flag missing");
  AST_READ_CLEAR: assert property (
    i_clk_en && rd_flags && set_flags == 8'h00 |=> st_q.flags == 8'h00)
    else $error("flag read did not clear");
  AST_OSC_MASK: assert property (
    i_clk_en && rd_flags && st_q.ien[`RTC_BIT_OSC_MASK]
    |=> !o_rdata[`RTC_BIT_OSC_HALTED])
    else $error("masked oscillator flag read as one");
  AST_IRQ_CAUSE: assert property (
    o_irq == ((st_q.flags[`RTC_BIT_ANALOG] && st_q.ien[`RTC_BIT_ANALOG])
           || (st_q.flags[`RTC_BIT_DIGITAL] && st_q.ien[`RTC_BIT_DIGITAL])
           || (st_q.flags[`RTC_BIT_ZERO] && st_q.ien[`RTC_BIT_ZERO])
           || (st_q.flags[`RTC_BIT_ALARM_TWO]
               && st_q.ien[`RTC_BIT_ALARM_TWO])
           || (st_q.flags[`RTC_BIT_ALARM_ONE]
               && st_q.ien[`RTC_BIT_ALARM_ONE])))
    else $error("interrupt not matching enabled flags");
  AST_SEC_WRAP: assert property (
    i_clk_en && sec_tick && !load_edge && st_q.live_sec == `RTC_SEC_LAST
    |=> st_q.live_sec == 8'h00)
    else $error("seconds did not wrap");
  AST_RUN_STEP: assert property (
    i_clk_en && run && !hold && cd_tick && st_q.count != 8'h00 && !wr_hit
    |=> st_q.count == $past(st_q.count) - 8'h01)
    else $error("running timer did not step down");
  AST_DRIFT_GATE: assert property (
    i_clk_en && !i_external_reference_enable
    && !st_q.flags[`RTC_BIT_SYNC_DRIFT]
    |=> !st_q.flags[`RTC_BIT_SYNC_DRIFT])
    else $error("drift flag set outside reference mode");
  AST_ANALOG_SET: assert property (
    i_clk_en && ana_event |=> st_q.flags[`RTC_BIT_ANALOG])
    else $error("analog event not flagged");
  AST_DIGITAL_SET: assert property (
    i_clk_en && dig_event |=> st_q.flags[`RTC_BIT_DIGITAL])
    else $error("digital event not flagged");
  AST_ALARM_SET: assert property (
    i_clk_en && i_events.alarm_one |=> st_q.flags[`RTC_BIT_ALARM_ONE])
    else $error("alarm one not flagged");
  AST_LOAD_COPY: assert property (
    i_clk_en && load_edge
    |=> st_q.live_sec == $past(st_q.prog_sec)
        && st_q.live_min == $past(st_q.prog_min)
        && st_q.live_hr == $past(st_q.prog_hr))
    else $error("time load did not copy programmed time");
  AST_HOURS_WRAP: assert property (
    i_clk_en && sec_tick && !load_edge && st_q.live_sec == `RTC_SEC_LAST
    && st_q.live_min == `RTC_SEC_LAST && st_q.live_hr == `RTC_HOURS_LAST
    |=> st_q.live_hr == 8'h00)
    else $error("hours did not wrap");

endmodule : rtc_timer_irq_time_regs
